// >>> logic/ldd_shadow_pkg.sv
package ldd_shadow_pkg;
	// shadow bank offsets on the management port
	localparam logic [7:0] OFS_TX_CONFIG_2 = 8'he5;
	localparam logic [7:0] OFS_TX_CONFIG_3 = 8'he6;
	localparam logic [7:0] OFS_TX_CONFIG_4 = 8'he7;
	localparam logic [7:0] OFS_TX_CONFIG_5 = 8'he8;
	localparam logic [7:0] OFS_TX_CONFIG_6 = 8'he9;
	localparam logic [7:0] OFS_TX_CONFIG_7 = 8'hea;
	localparam logic [7:0] OFS_RESERVED    = 8'heb;
	localparam logic [7:0] OFS_LOS_HIGH    = 8'hec;
	localparam logic [7:0] OFS_LOS_LOW     = 8'hed;
	localparam int         NUM_REGS        = 9;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [7:0] READ_FILL       = 8'h00;
	localparam logic [3:0] IDX_TX5  = 4'(OFS_TX_CONFIG_5 - OFS_TX_CONFIG_2);
	localparam logic [3:0] IDX_LOSH = 4'(OFS_LOS_HIGH - OFS_TX_CONFIG_2);
	localparam logic [3:0] IDX_LOSL = 4'(OFS_LOS_LOW - OFS_TX_CONFIG_2);

	// refresh sequence: items 0..5 are tx config 2..7, item 6 the los byte
	localparam logic [2:0] ITEM_TX5 = 3'h3;
	localparam logic [2:0] ITEM_LOS = 3'h6;

	// driver-side 3-wire addresses
	localparam logic [6:0] DRV_STATUS_ADDR = 7'h00;
	localparam logic [6:0] DRV_CONFIG_BASE = 7'h01;
	localparam logic [6:0] DRV_LOS_ADDR    = 7'h08;
	localparam int         STATUS_POR_BIT  = 7;

	// timing
	localparam int CLK_MHZ       = 25;
	localparam int LINK_HALF_NS  = 160;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int POLL_US       = 1000;
	localparam int POLL_CYC      = POLL_US * CLK_MHZ;
	localparam logic [3:0] LAST_BIT   = 4'hf;
	localparam logic [3:0] TURN_BIT   = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_POLL  = 3'b011,
		ST_POLLW = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_LOW  = 2'b01,
		LK_HIGH = 2'b10,
		LK_END  = 2'b11
	} link_state_t;
endpackage

// >>> logic/link_req_if.sv
`timescale 1ns/1ps
interface link_req_if;
	logic       start;
	logic       rd;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic       busy;
	logic       done;
	logic [7:0] rdata;
	modport master (output start, rd, addr, wdata,
		input busy, done, rdata);
	modport engine (input start, rd, addr, wdata,
		output busy, done, rdata);
endinterface

// >>> logic/link_shifter.sv
`timescale 1ns/1ps
module link_shifter (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic sda_in,
	link_req_if.engine req,
	output logic      sclk,
	output logic      cs,
	output logic      sda_out,
	output logic      sda_oe
);
	typedef struct packed {
		ldd_shadow_pkg::link_state_t st;
		logic [2:0]                  div;
		logic [3:0]                  bitc;
		logic [15:0]                 sh;
		logic                        rd;
		logic [7:0]                  rdata;
		logic                        sclk;
		logic                        cs;
		logic                        sda_o;
		logic                        oe;
		logic                        busy;
		logic                        done;
	} eng_t;

	eng_t s;
	eng_t next_s;
	logic tick;

	////////////////////////////////////////////////////////////////////////
	// link clock comes from a divider: this end owns it
	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		tick = (s.div == 3'(ldd_shadow_pkg::LINK_HALF_CYC - 1));
		if (s.st != ldd_shadow_pkg::LK_IDLE)
			next_s.div = tick ? 3'h0 : s.div + 3'h1;
		unique case (s.st)
			ldd_shadow_pkg::LK_IDLE:
				if (req.start)
				begin
					next_s.st = ldd_shadow_pkg::LK_LOW;
					next_s.sh = {req.rd, req.addr, req.wdata};
					next_s.rd = req.rd;
					next_s.bitc = 4'h0;
					next_s.div = 3'h0;
					next_s.cs = 1'b1;
					next_s.busy = 1'b1;
					next_s.oe = 1'b1;
					next_s.sda_o = req.rd;
				end
			ldd_shadow_pkg::LK_LOW:
				if (tick)
				begin
					next_s.sclk = 1'b1;
					next_s.st = ldd_shadow_pkg::LK_HIGH;
					// read data is taken on the rising edge of the data phase
					if (s.rd && s.bitc > ldd_shadow_pkg::TURN_BIT)
						next_s.rdata = {s.rdata[6:0], sda_in};
				end
			ldd_shadow_pkg::LK_HIGH:
				if (tick)
				begin
					next_s.sclk = 1'b0;
					if (s.bitc == ldd_shadow_pkg::LAST_BIT)
					begin
						next_s.st = ldd_shadow_pkg::LK_END;
						next_s.oe = 1'b0;
					end
					else
					begin
						next_s.bitc = s.bitc + 4'h1;
						next_s.st = ldd_shadow_pkg::LK_LOW;
						next_s.sh = {s.sh[14:0], 1'b0};
						next_s.sda_o = s.sh[14];
						// turn the line round for the driver's data byte
						next_s.oe = !(s.rd && s.bitc >= ldd_shadow_pkg::TURN_BIT);
					end
				end
			ldd_shadow_pkg::LK_END:
				if (tick)
				begin
					next_s.cs = 1'b0;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
					next_s.st = ldd_shadow_pkg::LK_IDLE;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign req.busy  = s.busy;
	assign req.done  = s.done;
	assign req.rdata = s.rdata;
	assign sclk      = s.sclk;
	assign cs        = s.cs;
	assign sda_out   = s.sda_o;
	assign sda_oe    = s.oe;

	chk_frame_select: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == ldd_shadow_pkg::LK_IDLE |-> !s.cs && !s.oe)
		else $error("select or drive active while idle");
endmodule

// >>> logic/ldd_shadow_regs.sv
`timescale 1ns/1ps
module ldd_shadow_regs #(
	parameter int POLL_CYCLES = ldd_shadow_pkg::POLL_CYC
) (
	input  wire logic       SYS_CLK,
	input  wire logic       RESET_N,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic       LEVEL1_PASSWORD_OK,
	input  wire logic       LEVEL2_PASSWORD_OK,
	input  wire logic       TABLE_RW_GRANT,
	input  wire logic       TABLE_READ_GRANT,
	output logic      [7:0] REG_RDATA,
	output logic            REG_ACK,
	output logic            REG_DENIED,
	input  wire logic       POWER_ON_ANALOG_LEVEL,
	input  wire logic       TX_DISABLE,
	input  wire logic       DUAL_CLOSED_LOOP,
	input  wire logic [7:0] DRIVER_TX_CONFIG_5_LUT,
	input  wire logic       LOS_THRESHOLD_SELECT,
	input  wire logic       AMP_BYTES_ENABLE,
	input  wire logic       AUTO_LINK_DISABLE,
	output logic            LINK_SCLK,
	output logic            LINK_CS,
	input  wire logic       LINK_SDA_IN,
	output logic            LINK_SDA_OUT,
	output logic            LINK_SDA_OE,
	output logic            REFRESH_BUSY
);
	typedef struct packed {
		logic [8:0][7:0]            cfg;
		logic                       poa_s1;
		logic                       poa_s2;
		logic                       txd_s1;
		logic                       txd_s2;
		logic                       txd_d;
		logic                       sda_s1;
		logic                       sda_s2;
		logic                       pwr_sent;
		logic                       pending;
		ldd_shadow_pkg::seq_state_t st;
		logic [2:0]                 item;
		logic [15:0]                poll_cnt;
		logic                       start;
		logic                       rd;
		logic [6:0]                 addr;
		logic [7:0]                 wdata;
		logic [7:0]                 rdata;
		logic                       ack;
		logic                       denied;
		logic                       busy;
	} regs_t;

	regs_t      s;
	regs_t      next_s;
	logic       trig;
	logic       por_seen;
	logic [3:0] idx;
	link_req_if lk ();

	////////////////////////////////////////////////////////////////////////
	function automatic logic read_ok(input logic pw1, input logic pw2,
		input logic rwg, input logic rdg);
		read_ok = pw2 | (pw1 & (rwg | rdg));
	endfunction

	function automatic logic write_ok(input logic pw1, input logic pw2,
		input logic rwg);
		write_ok = pw2 | (pw1 & rwg);
	endfunction

	function automatic logic in_bank(input logic [7:0] a);
		in_bank = a >= ldd_shadow_pkg::OFS_TX_CONFIG_2
			&& a <= ldd_shadow_pkg::OFS_LOS_LOW
			&& a != ldd_shadow_pkg::OFS_RESERVED;
	endfunction

	function automatic logic [7:0] item_value(input logic [2:0] it,
		input logic [8:0][7:0] c, input logic dcl,
		input logic [7:0] lut, input logic sel);
		if (it == ldd_shadow_pkg::ITEM_LOS)
			item_value = sel ? c[ldd_shadow_pkg::IDX_LOSH]
				: c[ldd_shadow_pkg::IDX_LOSL];
		else if (it == ldd_shadow_pkg::ITEM_TX5 && dcl)
			item_value = lut;
		else
			item_value = c[it];
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_s = s;
		next_s.poa_s1 = POWER_ON_ANALOG_LEVEL;
		next_s.poa_s2 = s.poa_s1;
		next_s.txd_s1 = TX_DISABLE;
		next_s.txd_s2 = s.txd_s1;
		next_s.txd_d = s.txd_s2;
		next_s.sda_s1 = LINK_SDA_IN;
		next_s.sda_s2 = s.sda_s1;
		next_s.start = 1'b0;
		next_s.ack = 1'b0;
		next_s.denied = 1'b0;
		idx = 4'(REG_ADDR - ldd_shadow_pkg::OFS_TX_CONFIG_2);

		// host access; reserved slot and foreign offsets read as fill
		if (REG_WR)
		begin
			next_s.ack = 1'b1;
			if (in_bank(REG_ADDR) && write_ok(LEVEL1_PASSWORD_OK,
				LEVEL2_PASSWORD_OK, TABLE_RW_GRANT))
				next_s.cfg[idx] = REG_WDATA;
			else
				next_s.denied = 1'b1;
		end
		else if (REG_RD)
		begin
			next_s.ack = 1'b1;
			if (in_bank(REG_ADDR) && read_ok(LEVEL1_PASSWORD_OK,
				LEVEL2_PASSWORD_OK, TABLE_RW_GRANT,
				TABLE_READ_GRANT))
				next_s.rdata = s.cfg[idx];
			else
			begin
				next_s.rdata = ldd_shadow_pkg::READ_FILL;
				next_s.denied = 1'b1;
			end
		end

		// refresh triggers
		if (s.poa_s2 && !s.pwr_sent)
			next_s.pwr_sent = 1'b1;
		por_seen = s.st == ldd_shadow_pkg::ST_POLLW && lk.done
			&& lk.rdata[ldd_shadow_pkg::STATUS_POR_BIT];
		trig = (s.poa_s2 && !s.pwr_sent)
			|| (s.txd_s2 && !s.txd_d)
			|| por_seen;

		unique case (s.st)
			ldd_shadow_pkg::ST_IDLE:
				if (AUTO_LINK_DISABLE)
				begin
					next_s.pending = 1'b0;
					next_s.poll_cnt = 16'(POLL_CYCLES - 1);
				end
				else if (s.pending)
				begin
					next_s.pending = 1'b0;
					next_s.item = 3'h0;
					next_s.st = ldd_shadow_pkg::ST_LOAD;
				end
				else if (s.poll_cnt == 16'h0000)
				begin
					next_s.poll_cnt = 16'(POLL_CYCLES - 1);
					next_s.st = ldd_shadow_pkg::ST_POLL;
				end
				else
					next_s.poll_cnt = s.poll_cnt - 16'h0001;
			ldd_shadow_pkg::ST_LOAD:
				if (AUTO_LINK_DISABLE)
					next_s.st = ldd_shadow_pkg::ST_IDLE;
				else if (s.item == ldd_shadow_pkg::ITEM_LOS
					&& !AMP_BYTES_ENABLE)
					next_s.st = ldd_shadow_pkg::ST_IDLE;
				else if (!lk.busy)
				begin
					next_s.start = 1'b1;
					next_s.rd = 1'b0;
					next_s.addr = (s.item == ldd_shadow_pkg::ITEM_LOS)
						? ldd_shadow_pkg::DRV_LOS_ADDR
						: ldd_shadow_pkg::DRV_CONFIG_BASE + 7'(s.item);
					next_s.wdata = item_value(s.item, s.cfg,
						DUAL_CLOSED_LOOP, DRIVER_TX_CONFIG_5_LUT,
						LOS_THRESHOLD_SELECT);
					next_s.st = ldd_shadow_pkg::ST_WAIT;
				end
			ldd_shadow_pkg::ST_WAIT:
				// a sequence runs to its end before a new one, unless the auto link switch stops it in ST_LOAD
				if (lk.done)
				begin
					if (s.item == ldd_shadow_pkg::ITEM_LOS)
						next_s.st = ldd_shadow_pkg::ST_IDLE;
					else
					begin
						next_s.item = s.item + 3'h1;
						next_s.st = ldd_shadow_pkg::ST_LOAD;
					end
				end
			ldd_shadow_pkg::ST_POLL:
				if (AUTO_LINK_DISABLE)
					next_s.st = ldd_shadow_pkg::ST_IDLE;
				else if (!lk.busy)
				begin
					next_s.start = 1'b1;
					next_s.rd = 1'b1;
					next_s.addr = ldd_shadow_pkg::DRV_STATUS_ADDR;
					next_s.st = ldd_shadow_pkg::ST_POLLW;
				end
			ldd_shadow_pkg::ST_POLLW:
				if (lk.done)
					next_s.st = ldd_shadow_pkg::ST_IDLE;
			default:
				next_s.st = ldd_shadow_pkg::ST_IDLE;
		endcase

		// set beats the clear at sequence start; many triggers fold to one
		if (trig && !AUTO_LINK_DISABLE)
			next_s.pending = 1'b1;
		next_s.busy = next_s.st == ldd_shadow_pkg::ST_LOAD
			|| next_s.st == ldd_shadow_pkg::ST_WAIT;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			s <= '0;
			s.cfg <= {ldd_shadow_pkg::NUM_REGS{ldd_shadow_pkg::REG_RESET}};
			s.poll_cnt <= 16'(POLL_CYCLES - 1);
		end
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////
	assign lk.start = s.start;
	assign lk.rd    = s.rd;
	assign lk.addr  = s.addr;
	assign lk.wdata = s.wdata;

	link_shifter u_link (
		.clk     (SYS_CLK),
		.rst_n   (RESET_N),
		.sda_in  (s.sda_s2),
		.req     (lk),
		.sclk    (LINK_SCLK),
		.cs      (LINK_CS),
		.sda_out (LINK_SDA_OUT),
		.sda_oe  (LINK_SDA_OE)
	);

	assign REG_RDATA    = s.rdata;
	assign REG_ACK      = s.ack;
	assign REG_DENIED   = s.denied;
	assign REFRESH_BUSY = s.busy;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	chk_powerup_arms: assert property (
		s.poa_s2 && !s.pwr_sent && !AUTO_LINK_DISABLE |=> s.pending)
		else $error("power-up did not arm a refresh");
	chk_por_rearms: assert property (
		por_seen && !AUTO_LINK_DISABLE |=> s.pending)
		else $error("driver power-on flag ignored");
	chk_txd_edge_arms: assert property (
		$rose(s.txd_s2) && !AUTO_LINK_DISABLE |=> s.pending)
		else $error("tx disable edge ignored");
	chk_tx5_source: assert property (
		s.start && !s.rd && s.addr == ldd_shadow_pkg::DRV_CONFIG_BASE
		+ 7'(ldd_shadow_pkg::ITEM_TX5) |-> s.wdata == ($past(DUAL_CLOSED_LOOP)
		? $past(DRIVER_TX_CONFIG_5_LUT) : $past(s.cfg[ldd_shadow_pkg::IDX_TX5])))
		else $error("wrong source for tx config 5");
	chk_los_choice: assert property (
		s.start && s.addr == ldd_shadow_pkg::DRV_LOS_ADDR
		|-> s.wdata == ($past(LOS_THRESHOLD_SELECT)
		? $past(s.cfg[ldd_shadow_pkg::IDX_LOSH])
		: $past(s.cfg[ldd_shadow_pkg::IDX_LOSL])))
		else $error("wrong los threshold sent");
	chk_read_guard: assert property (
		REG_RD && !REG_WR && !read_ok(LEVEL1_PASSWORD_OK, LEVEL2_PASSWORD_OK,
		TABLE_RW_GRANT, TABLE_READ_GRANT)
		|=> REG_ACK && REG_DENIED && REG_RDATA == ldd_shadow_pkg::READ_FILL)
		else $error("read without access granted");
	chk_write_guard: assert property (
		REG_WR && !write_ok(LEVEL1_PASSWORD_OK, LEVEL2_PASSWORD_OK,
		TABLE_RW_GRANT) |=> $stable(s.cfg) && REG_DENIED)
		else $error("write without access changed the bank");
	chk_reserved_slot: assert property (
		(REG_RD || REG_WR) && REG_ADDR == ldd_shadow_pkg::OFS_RESERVED
		|=> REG_DENIED && $stable(s.cfg))
		else $error("reserved slot was reached");
	chk_auto_quiet: assert property (
		AUTO_LINK_DISABLE && s.st == ldd_shadow_pkg::ST_IDLE
		|=> !s.start [*2])
		else $error("link traffic while disabled");
	chk_amp_skip: assert property (
		s.st == ldd_shadow_pkg::ST_LOAD && s.item == ldd_shadow_pkg::ITEM_LOS
		&& !AMP_BYTES_ENABLE |=> s.st == ldd_shadow_pkg::ST_IDLE && !s.start)
		else $error("amplifier byte sent while disabled");
	chk_single_rerun: assert property (
		s.st == ldd_shadow_pkg::ST_WAIT && lk.done
		&& s.item == ldd_shadow_pkg::ITEM_LOS && s.pending
		&& !AUTO_LINK_DISABLE |=> s.st == ldd_shadow_pkg::ST_IDLE
		##1 (s.st == ldd_shadow_pkg::ST_LOAD || $past(AUTO_LINK_DISABLE)))
		else $error("queued refresh not started");

	cov_txd_refresh: cover property ($rose(s.txd_s2) ##[1:20] s.start);
	cov_por_refresh: cover property (por_seen ##[1:20] s.start);
	cov_dcl_send: cover property (s.start && DUAL_CLOSED_LOOP);
endmodule

// >>> bench/ldd_partner.sv
`timescale 1ns/1ps
module ldd_partner (
	input  wire logic sclk,
	input  wire logic cs,
	input  wire logic sda_out,
	input  wire logic sda_oe,
	output logic      sda_in
);
	logic [15:0] sr = 16'h0000;
	logic [15:0] frames[$];
	int          cnt = 0;
	logic        rd = 1'b0;
	logic        pin = 1'b0;
	logic        por_flag = 1'b0;

	assign sda_in = sda_oe ? sda_out : pin;

	////////////////////////////////////////////////////////////////////////
	always @(posedge sclk)
	begin
		if (cs)
		begin
			if (cnt == 0)
				rd = sda_in;
			sr = {sr[14:0], sda_in};
			cnt++;
		end
	end

	// answer bits held a whole bit; released line toggles at every falling link clock
	always @(negedge sclk)
	begin
		if (cs && rd && cnt >= 8 && cnt < 16)
		begin
			pin = (cnt == 8) ? por_flag : 1'b0;
			// flag clears only once it has gone out in a status byte,
			// so a flag raised mid-read is not lost
			if (cnt == 8 && sr[6:0] == 7'h00)
				por_flag = 1'b0;
		end
		else
			pin = ~pin;
	end

	always @(negedge cs)
	begin
		if (cnt == 16)
			frames.push_back(sr);
		cnt = 0;
	end
endmodule

// >>> bench/ldd_shadow_regs_test.sv
`timescale 1ns/1ps
module ldd_shadow_regs_test;
	localparam int POLL = 200;
	localparam int LIMIT = 20000;
	logic       sys_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [3:0] perm = 4'h0;
	logic [7:0] reg_rdata;
	logic       reg_ack;
	logic       reg_denied;
	logic       power_on_analog_level = 1'b0;
	logic       txd = 1'b0;
	logic       dcl = 1'b0;
	logic [7:0] lut = 8'h00;
	logic       sel = 1'b0;
	logic       amp = 1'b0;
	logic       ald = 1'b0;
	logic       sclk;
	logic       cs;
	logic       sda_in;
	logic       sda_out;
	logic       sda_oe;
	logic       busy;
	logic [7:0] bank[9];
	int         n_fail = 0;
	int         check_count = 0;
	int         cycles = 0;

	ldd_shadow_regs #(.POLL_CYCLES(POLL)) u_dut (
		.SYS_CLK(sys_clk),
		.RESET_N(reset_n),
		.REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata),
		.REG_WR(reg_wr),
		.REG_RD(reg_rd),
		.LEVEL1_PASSWORD_OK(perm[3]),
		.LEVEL2_PASSWORD_OK(perm[2]),
		.TABLE_RW_GRANT(perm[1]),
		.TABLE_READ_GRANT(perm[0]),
		.REG_RDATA(reg_rdata),
		.REG_ACK(reg_ack),
		.REG_DENIED(reg_denied),
		.POWER_ON_ANALOG_LEVEL(power_on_analog_level),
		.TX_DISABLE(txd),
		.DUAL_CLOSED_LOOP(dcl),
		.DRIVER_TX_CONFIG_5_LUT(lut),
		.LOS_THRESHOLD_SELECT(sel),
		.AMP_BYTES_ENABLE(amp),
		.AUTO_LINK_DISABLE(ald),
		.LINK_SCLK(sclk),
		.LINK_CS(cs),
		.LINK_SDA_IN(sda_in),
		.LINK_SDA_OUT(sda_out),
		.LINK_SDA_OE(sda_oe),
		.REFRESH_BUSY(busy)
	);

	ldd_partner u_model (
		.sclk(sclk),
		.cs(cs),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.sda_in(sda_in)
	);

	always #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one strobe, answer looked at in the cycle that it stands
	task automatic access(logic wr, logic [3:0] i, logic [7:0] d,
		logic den, logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= ldd_shadow_pkg::OFS_TX_CONFIG_2 + 8'(i);
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		check("ack", 16'h1, 16'(reg_ack));
		check("denied", 16'(den), 16'(reg_denied));
		if (!wr)
			check("rdata", 16'(exp), 16'(reg_rdata));
	endtask

	// watches busy for a fixed 600 cycles, then waits for busy to stay low 60 cycles, then compares
	task automatic expect_refresh(int nseq);
		int q;
		int ni;
		logic seen;
		logic [15:0] w[$];
		logic [15:0] e;
		seen = 1'b0;
		q = 0;
		// a status poll in flight can delay a poll-driven refresh
		repeat (600)
		begin
			@(posedge sys_clk);
			seen |= busy;
		end
		ni = amp ? 7 : 6;
		while (q < 60)
		begin
			@(posedge sys_clk);
			q = busy ? 0 : q + 1;
		end
		check("busy", 16'(nseq != 0), 16'(seen));
		foreach (u_model.frames[j])
			if (!u_model.frames[j][15])
				w.push_back(u_model.frames[j]);
		u_model.frames.delete();
		check("frames", 16'(nseq * ni), 16'(w.size()));
		for (int k = 0; k < w.size() && k < nseq * ni; k++)
		begin
			q = k % ni;
			if (q == 6)
				e = {8'h08, sel ? bank[7] : bank[8]};
			else if (q == 3 && dcl)
				e = {8'h04, lut};
			else
				e = {8'(q + 1), bank[q]};
			check("frame", e, w[k]);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic wok;
		logic rok;
		logic [7:0] d;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		perm <= 4'h4;
		for (int i = 0; i < 9; i++)
		begin
			bank[i] = 8'h00;
			access(0, 4'(i), 8'h00, i == 6, 8'h00);
		end
		$display("test reset values done");
		for (int p = 0; p < 16; p++)
		begin
			@(posedge sys_clk);
			perm <= 4'(p);
			wok = p[2] | (p[3] & p[1]);
			rok = wok | (p[3] & p[0]);
			d = 8'(8'h20 + p);
			access(1, 4'h4, d, !wok, 8'h00);
			if (wok)
				bank[4] = d;
			access(0, 4'h4, 8'h00, !rok, rok ? bank[4] : 8'h00);
		end
		$display("test access levels done");
		@(posedge sys_clk);
		perm <= 4'h4;
		access(1, 4'h6, 8'h77, 1'b1, 8'h00);
		access(0, 4'h6, 8'h00, 1'b1, 8'h00);
		access(0, 4'hf, 8'h00, 1'b1, 8'h00);
		for (int i = 0; i < 9; i++)
		begin
			d = 8'(8'h3c + 8'h25 * i);
			if (i != 6)
			begin
				access(1, 4'(i), d, 1'b0, 8'h00);
				bank[i] = d;
			end
		end
		$display("test reserved slot done");
		@(posedge sys_clk);
		amp <= 1'b1;
		power_on_analog_level <= 1'b1;
		expect_refresh(1);
		$display("test power up done");
		dcl <= 1'b1;
		lut <= 8'h5a;
		sel <= 1'b1;
		txd <= 1'b1;
		expect_refresh(1);
		txd <= 1'b0;
		$display("test transmit disable done");
		dcl <= 1'b0;
		amp <= 1'b0;
		u_model.por_flag = 1'b1;
		expect_refresh(1);
		$display("test driver power on done");
		amp <= 1'b1;
		txd <= 1'b1;
		repeat (200) @(posedge sys_clk);
		txd <= 1'b0;
		repeat (10) @(posedge sys_clk);
		txd <= 1'b1;
		repeat (10) @(posedge sys_clk);
		txd <= 1'b0;
		repeat (10) @(posedge sys_clk);
		txd <= 1'b1;
		expect_refresh(2);
		$display("test repeated triggers done");
		ald <= 1'b1;
		txd <= 1'b0;
		repeat (10) @(posedge sys_clk);
		txd <= 1'b1;
		u_model.por_flag = 1'b1;
		expect_refresh(0);
		$display("test link disabled done");
		print_verdict();
	end
endmodule
